// file: src/ltcb_pkg.sv
// package of offsets, fields, reset values and decode tables for the trim config bank
package ltcb_pkg;
    // register byte addresses
    localparam logic [7:0] LTCB_ADDR_TRIM_AB  = 8'h67;   // sink_trim_ch1_ch2
    localparam logic [7:0] LTCB_ADDR_TRIM_CD  = 8'h68;   // sink_trim_ch3_ch4
    localparam logic [7:0] LTCB_ADDR_GAIN_FLT = 8'h69;   // temp_gain_and_comparator_filter
    localparam logic [7:0] LTCB_ADDR_PSW_SS   = 8'h6a;   // power_switch_and_soft_start
    localparam int         LTCB_NREG          = 4;       // registers in the bank
    localparam int         LTCB_NCH           = 4;       // sink channels

    // field positions
    localparam int LTCB_HI_LSB   = 4;                    // upper nibble lsb
    localparam int LTCB_LO_LSB   = 0;                    // lower nibble lsb
    localparam int LTCB_DIM_EN   = 7;                    // thermal dimming enable bit
    localparam int LTCB_NTYPE    = 6;                    // n-channel switch select bit
    localparam int LTCB_SS_LSB   = 4;                    // soft-start code lsb
    localparam int LTCB_OCP_LSB  = 2;                    // overcurrent code lsb
    localparam int LTCB_GATE_LSB = 0;                    // gate current code lsb

    // reset values
    localparam logic [7:0] LTCB_RST_TRIM     = 8'h77;    // zero correction on both sinks
    localparam logic [7:0] LTCB_RST_GAIN_FLT = 8'h00;
    localparam logic [7:0] LTCB_RST_PSW_SS   = 8'h08;    // ocp code 10 (6 a)
    localparam logic [1:0] LTCB_OCP_DEFAULT  = 2'h2;     // limit used for reserved codes
    localparam logic [3:0] LTCB_TRIM_ZERO    = 4'h7;     // no adjustment code

    // soft-start times in ms and clock counts at 100 mhz
    localparam int LTCB_CLK_KHZ  = 100000;
    localparam int LTCB_SS0_MS   = 5;
    localparam int LTCB_SS1_MS   = 10;
    localparam int LTCB_SS2_MS   = 20;
    localparam int LTCB_SS3_MS   = 50;
    localparam int LTCB_SS0_CYC  = LTCB_SS0_MS * LTCB_CLK_KHZ;
    localparam int LTCB_SS1_CYC  = LTCB_SS1_MS * LTCB_CLK_KHZ;
    localparam int LTCB_SS2_CYC  = LTCB_SS2_MS * LTCB_CLK_KHZ;
    localparam int LTCB_SS3_CYC  = LTCB_SS3_MS * LTCB_CLK_KHZ;

    // comparator filter lengths in pwm clock cycles per code
    localparam logic [8:0] LTCB_FLT_LEN [16] = '{
        9'd5,   9'd10,  9'd20,  9'd40,  9'd60,  9'd80,  9'd100, 9'd140,
        9'd180, 9'd220, 9'd260, 9'd300, 9'd340, 9'd380, 9'd420, 9'd460};

    // sink correction in units of 0.1 percent, signed
    localparam logic signed [7:0] LTCB_TRIM_PERMIL [16] = '{
        8'sd65,  8'sd56,  8'sd47,  8'sd37,  8'sd28,  8'sd19,  8'sd9,   8'sd0,
        -8'sd9,  -8'sd19, -8'sd28, -8'sd37, -8'sd47, -8'sd56, -8'sd65, -8'sd74};

    // gate current in ua per code, p-type then n-type
    localparam logic [11:0] LTCB_GATE_P_UA [4] = '{12'd55, 12'd110, 12'd220, 12'd440};
    localparam logic [11:0] LTCB_GATE_N_UA [4] = '{12'd300, 12'd500, 12'd1000, 12'd2200};

    // overcurrent limit in amps per code
    localparam logic [3:0] LTCB_OCP_A_6 = 4'h6;
    localparam logic [3:0] LTCB_OCP_A_8 = 4'h8;

    // filter state
    typedef enum logic [1:0] {LTCB_FLT_IDLE, LTCB_FLT_COUNT, LTCB_FLT_DONE} ltcb_flt_t;
endpackage

// file: src/ltcb_regfile.sv
// byte-wide storage for the four trim and config registers
`timescale 1ns/1ps
`default_nettype none
module ltcb_regfile
    import ltcb_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       srst,
    // write side
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_idx,
    input  wire logic [7:0] wr_data,
    // read side
    input  wire logic [1:0] rd_idx,
    output var  logic [7:0] rd_data,
    // all registers flat, index 0 in the low byte
    output var  logic [31:0] regs
);
    logic [7:0] mem_q [LTCB_NREG];   // storage cells

    // one register per entry, reset to defined values
    genvar gi;
    generate
        for (gi = 0; gi < LTCB_NREG; gi++) begin : g_reg
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    mem_q[gi] <= (gi < 2) ? LTCB_RST_TRIM : ((gi == 2) ? LTCB_RST_GAIN_FLT : LTCB_RST_PSW_SS);
                end else if (wr_en && wr_idx == 2'(gi)) begin
                    mem_q[gi] <= wr_data;
                end
            end
            assign regs[gi*8 +: 8] = mem_q[gi];
        end
    endgenerate

    // registered read port
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem_q[rd_idx];
        end
    end
endmodule
`default_nettype wire

// file: src/ltcb_cmp_filter.sv
// headroom comparator qualifier: passes a level only after it held for n pwm clocks
`timescale 1ns/1ps
`default_nettype none
module ltcb_cmp_filter
    import ltcb_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       srst,
    // pwm generator clock tick and raw comparator
    input  wire logic       pwm_tick,
    input  wire logic       cmp_raw,
    input  wire logic [3:0] len_code,
    // filtered result
    output var  logic       cmp_filt
);
    logic [2:0] sync_q;              // three-stage synchroniser
    logic       stable_q;            // last agreed level
    logic [8:0] cnt_q;               // pwm cycles held
    logic [8:0] len;                 // target length
    ltcb_flt_t  st_q;

    assign len = LTCB_FLT_LEN[len_code];

    // synchronise the asynchronous comparator
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], cmp_raw};
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stable_q <= 1'b0;
        end else if (sync_q[1] == sync_q[2]) begin
            stable_q <= sync_q[2];
        end
    end

    // count pwm ticks while the level differs from output
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q     <= LTCB_FLT_IDLE;
            cnt_q    <= 9'h000;
            cmp_filt <= 1'b0;
        end else begin
            unique case (st_q)
                LTCB_FLT_IDLE: begin
                    cnt_q <= 9'h000;
                    if (stable_q != cmp_filt) begin
                        st_q <= LTCB_FLT_COUNT;
                    end
                end
                LTCB_FLT_COUNT: begin
                    if (stable_q == cmp_filt) begin
                        st_q <= LTCB_FLT_IDLE;   // glitch, restart
                    end else if (pwm_tick) begin
                        cnt_q <= cnt_q + 9'h001;
                        if (cnt_q + 9'h001 >= len) begin
                            st_q <= LTCB_FLT_DONE;
                        end
                    end
                end
                LTCB_FLT_DONE: begin
                    cmp_filt <= stable_q;
                    st_q     <= LTCB_FLT_IDLE;
                end
                // unused encoding of the two-bit state falls back to idle
                default: begin
                    st_q <= LTCB_FLT_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: src/ltcb_top.sv
// trim and power-switch configuration bank with decoded controls
// Summary of operation
// - sink b trim in bits 7:4 of 0x67
// - sink a trim in bits 3:0 of 0x67
// - sink d trim in bits 7:4 of 0x68
// - sink c trim in bits 3:0 of 0x68
// - comparator filtered for coded pwm cycle count
// - thermal dimming gain in bits 7:4 of 0x69
// - bit 7 of 0x6a enables thermal dimming
// - bit 6 of 0x6a selects n-type switch
// - bits 5:4 pick 5/10/20/50 ms soft-start
// - bits 3:2 pick 6 a or 8 a limit
// - p-type gate current 55 to 440 ua
// - n-type gate current only in fault recovery
`timescale 1ns/1ps
`default_nettype none
module ltcb_top
    import ltcb_pkg::*;
(
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               srst,
    // register access from the serial front end
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    output var  logic [7:0]         reg_rdata,
    output var  logic               reg_rvalid,
    output var  logic               reg_hit,
    // sink correction codes and values
    output var  logic [3:0]         sink_a_trim_code,
    output var  logic [3:0]         sink_b_trim_code,
    output var  logic [3:0]         sink_c_trim_code,
    output var  logic [3:0]         sink_d_trim_code,
    output var  logic signed [7:0]  sink_a_trim_permil,
    output var  logic signed [7:0]  sink_b_trim_permil,
    output var  logic signed [7:0]  sink_c_trim_permil,
    output var  logic signed [7:0]  sink_d_trim_permil,
    // thermal dimming
    output var  logic [3:0]         thermal_dim_gain,
    output var  logic               thermal_dim_enable,
    // headroom comparator
    input  wire logic               pwm_tick,
    input  wire logic               headroom_cmp_raw,
    output var  logic [3:0]         headroom_cmp_filter_len,
    output var  logic               headroom_cmp_qualified,
    // power-line switch
    input  wire logic               fault_recovery,
    output var  logic               power_switch_n_type,
    output var  logic [1:0]         power_switch_ocp_limit,
    output var  logic [3:0]         power_switch_ocp_amps,
    output var  logic [1:0]         power_switch_gate_current,
    output var  logic [11:0]        gate_current_ua,
    // soft-start
    input  wire logic               soft_start_go,
    output var  logic               soft_start_busy
);
    logic [31:0] regs;           // flat register image
    logic [7:0]  trim_ab;        // sink a and b
    logic [7:0]  trim_cd;        // sink c and d
    logic [7:0]  gain_flt;       // gain and filter
    logic [7:0]  psw_ss;         // switch and soft-start
    logic        hit;            // address inside the bank
    logic [1:0]  idx;            // bank index
    logic        rd_pend_q;      // read answer due next cycle
    logic        hit_q;          // read hit delayed
    logic [7:0]  rf_rdata;       // read data from storage
    logic [1:0]  ocp_code;       // raw limit code
    logic [31:0] ss_len;         // soft-start length
    logic [31:0] ss_cnt_q;       // soft-start counter

    // address decode; the four registers are contiguous
    assign hit = (reg_addr >= LTCB_ADDR_TRIM_AB) && (reg_addr <= LTCB_ADDR_PSW_SS);
    assign idx = 2'(reg_addr - LTCB_ADDR_TRIM_AB);
    assign reg_hit = hit;

    ltcb_regfile u_rf (
        .sys_clk (sys_clk),
        .srst    (srst),
        .wr_en   (reg_wr && hit),
        .wr_idx  (idx),
        .wr_data (reg_wdata),
        .rd_idx  (idx),
        .rd_data (rf_rdata),
        .regs    (regs)
    );

    assign trim_ab  = regs[7:0];
    assign trim_cd  = regs[15:8];
    assign gain_flt = regs[23:16];
    assign psw_ss   = regs[31:24];

    // read answer one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_pend_q <= 1'b0;
            hit_q     <= 1'b0;
        end else begin
            rd_pend_q <= reg_rd;
            hit_q     <= hit;
        end
    end
    assign reg_rvalid = rd_pend_q;
    assign reg_rdata  = (rd_pend_q && hit_q) ? rf_rdata : 8'h00;

    // field extraction and per-channel decode, registered
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sink_a_trim_code   <= LTCB_TRIM_ZERO;
            sink_b_trim_code   <= LTCB_TRIM_ZERO;
            sink_c_trim_code   <= LTCB_TRIM_ZERO;
            sink_d_trim_code   <= LTCB_TRIM_ZERO;
            sink_a_trim_permil <= 8'sd0;
            sink_b_trim_permil <= 8'sd0;
            sink_c_trim_permil <= 8'sd0;
            sink_d_trim_permil <= 8'sd0;
        end else begin
            sink_b_trim_code   <= trim_ab[LTCB_HI_LSB +: 4];
            sink_b_trim_permil <= LTCB_TRIM_PERMIL[trim_ab[LTCB_HI_LSB +: 4]];
            sink_a_trim_code   <= trim_ab[LTCB_LO_LSB +: 4];
            sink_a_trim_permil <= LTCB_TRIM_PERMIL[trim_ab[LTCB_LO_LSB +: 4]];
            sink_d_trim_code   <= trim_cd[LTCB_HI_LSB +: 4];
            sink_d_trim_permil <= LTCB_TRIM_PERMIL[trim_cd[LTCB_HI_LSB +: 4]];
            sink_c_trim_code   <= trim_cd[LTCB_LO_LSB +: 4];
            sink_c_trim_permil <= LTCB_TRIM_PERMIL[trim_cd[LTCB_LO_LSB +: 4]];
        end
    end

    // thermal dimming and filter fields
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            thermal_dim_gain        <= 4'h0;
            thermal_dim_enable      <= 1'b0;
            headroom_cmp_filter_len <= 4'h0;
        end else begin
            thermal_dim_gain        <= gain_flt[LTCB_HI_LSB +: 4];
            thermal_dim_enable      <= psw_ss[LTCB_DIM_EN];
            headroom_cmp_filter_len <= gain_flt[LTCB_LO_LSB +: 4];
        end
    end

    // comparator qualifier uses the live code so a rewrite takes effect at once
    ltcb_cmp_filter u_flt (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .pwm_tick (pwm_tick),
        .cmp_raw  (headroom_cmp_raw),
        .len_code (gain_flt[LTCB_LO_LSB +: 4]),
        .cmp_filt (headroom_cmp_qualified)
    );

    // reserved limit codes map to the default so the trip point is never undefined
    assign ocp_code = psw_ss[LTCB_OCP_LSB +: 2];

    // power switch decode
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            power_switch_n_type       <= 1'b0;
            power_switch_ocp_limit    <= LTCB_OCP_DEFAULT;
            power_switch_ocp_amps     <= LTCB_OCP_A_6;
            power_switch_gate_current <= 2'h0;
            gate_current_ua           <= 12'h000;
        end else begin
            power_switch_n_type       <= psw_ss[LTCB_NTYPE];
            power_switch_gate_current <= psw_ss[LTCB_GATE_LSB +: 2];
            if (ocp_code[1]) begin
                power_switch_ocp_limit <= ocp_code;
                power_switch_ocp_amps  <= ocp_code[0] ? LTCB_OCP_A_8 : LTCB_OCP_A_6;
            end else begin
                power_switch_ocp_limit <= LTCB_OCP_DEFAULT;
                power_switch_ocp_amps  <= LTCB_OCP_A_6;
            end
            if (!psw_ss[LTCB_NTYPE]) begin
                gate_current_ua <= LTCB_GATE_P_UA[psw_ss[LTCB_GATE_LSB +: 2]];
            end else if (fault_recovery) begin
                gate_current_ua <= LTCB_GATE_N_UA[psw_ss[LTCB_GATE_LSB +: 2]];
            end else begin
                gate_current_ua <= 12'h000;
            end
        end
    end

    // soft-start length per code
    always_comb begin
        unique case (psw_ss[LTCB_SS_LSB +: 2])
            2'h0: ss_len = LTCB_SS0_CYC;
            2'h1: ss_len = LTCB_SS1_CYC;
            2'h2: ss_len = LTCB_SS2_CYC;
            2'h3: ss_len = LTCB_SS3_CYC;
        endcase
    end

    // soft-start timer; a new go restarts the ramp
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ss_cnt_q        <= 32'h0;
            soft_start_busy <= 1'b0;
        end else if (soft_start_go) begin
            ss_cnt_q        <= 32'h1;
            soft_start_busy <= 1'b1;
        end else if (soft_start_busy) begin
            if (ss_cnt_q >= ss_len) begin
                soft_start_busy <= 1'b0;
            end else begin
                ss_cnt_q <= ss_cnt_q + 32'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/ltcb_checker.sv
// concurrent checks on the trim config bank ports
`timescale 1ns/1ps
`default_nettype none
module ltcb_checker
    import ltcb_pkg::*;
(
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              srst,
    // register access
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic [7:0]        reg_rdata,
    input wire logic              reg_rvalid,
    input wire logic              reg_hit,
    // decoded fields
    input wire logic [3:0]        sink_a_trim_code,
    input wire logic [3:0]        sink_b_trim_code,
    input wire logic [3:0]        sink_c_trim_code,
    input wire logic [3:0]        sink_d_trim_code,
    input wire logic [3:0]        thermal_dim_gain,
    input wire logic              thermal_dim_enable,
    input wire logic [3:0]        headroom_cmp_filter_len,
    // comparator, switch and soft-start
    input wire logic              headroom_cmp_raw,
    input wire logic              headroom_cmp_qualified,
    input wire logic              fault_recovery,
    input wire logic              power_switch_n_type,
    input wire logic [1:0]        power_switch_ocp_limit,
    input wire logic [3:0]        power_switch_ocp_amps,
    input wire logic [1:0]        power_switch_gate_current,
    input wire logic [11:0]       gate_current_ua,
    input wire logic              soft_start_go,
    input wire logic              soft_start_busy
);
    // one clock domain, so clock and reset are set once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // read answer comes exactly one cycle later
    chk_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
    // an address outside the bank reads as zero
    chk_unmapped_read: assert property (reg_rd && !reg_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_trim_ab_fields: assert property (reg_wr && reg_addr == 8'h67 |-> ##2
        {sink_b_trim_code, sink_a_trim_code} == $past(reg_wdata, 2)) else $error("trim a/b field wrong");
    chk_trim_cd_fields: assert property (reg_wr && reg_addr == 8'h68 |-> ##2
        {sink_d_trim_code, sink_c_trim_code} == $past(reg_wdata, 2)) else $error("trim c/d field wrong");
    chk_gain_filter_fields: assert property (reg_wr && reg_addr == 8'h69 |-> ##2
        {thermal_dim_gain, headroom_cmp_filter_len} == $past(reg_wdata, 2)) else $error("gain/filter wrong");
    chk_switch_fields: assert property (reg_wr && reg_addr == 8'h6a |-> ##2
        {thermal_dim_enable, power_switch_n_type, power_switch_gate_current}
        == {$past(reg_wdata[7:6], 2), $past(reg_wdata[1:0], 2)}) else $error("switch fields wrong");
    // reserved limit codes never reach the output
    chk_ocp_limit_map: assert property (power_switch_ocp_limit[1] &&
        power_switch_ocp_amps == (power_switch_ocp_limit == 2'h3 ? 4'h8 : 4'h6)) else $error("ocp map wrong");
    // n-type gate current stays off outside fault recovery
    chk_ntype_gate_off: assert property ((power_switch_n_type && !fault_recovery)[*3] |->
        gate_current_ua == 12'h000) else $error("n-type gate current outside recovery");
    chk_soft_start_rise: assert property (soft_start_go |=> soft_start_busy) else $error("busy late");
    // the raw input must already have been high seven cycles before the output rises
    chk_qual_rise: assert property ($rose(headroom_cmp_qualified) |-> $past(headroom_cmp_raw, 7))
        else $error("qualified rose too early");

    // main scenarios reached
    cov_switch_write: cover property (reg_wr && reg_addr == 8'h6a);
    cov_soft_start: cover property (soft_start_go ##1 soft_start_busy);
    cov_qual_rise: cover property ($rose(headroom_cmp_qualified));
    cov_unmapped: cover property (reg_rd && !reg_hit);
endmodule

bind ltcb_top ltcb_checker i_ltcb_checker (.sys_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .reg_hit, .sink_a_trim_code, .sink_b_trim_code, .sink_c_trim_code,
    .sink_d_trim_code, .thermal_dim_gain, .thermal_dim_enable, .headroom_cmp_filter_len, .headroom_cmp_raw,
    .headroom_cmp_qualified, .fault_recovery, .power_switch_n_type, .power_switch_ocp_limit,
    .power_switch_ocp_amps, .power_switch_gate_current, .gate_current_ua, .soft_start_go, .soft_start_busy);
`default_nettype wire

// file: bench/ltcb_top_tb.sv
// self-checking bench for the trim config bank
`timescale 1ns/1ps
`default_nettype none
module ltcb_top_tb;
    import ltcb_pkg::*;
    // stimulus
    logic        sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, pwm_tick = 0;
    logic        headroom_cmp_raw = 0, fault_recovery = 0, soft_start_go = 0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
    // observed
    logic [7:0]  reg_rdata;
    logic        reg_rvalid, reg_hit, thermal_dim_enable, headroom_cmp_qualified, power_switch_n_type;
    logic [3:0]  sink_a_trim_code, sink_b_trim_code, sink_c_trim_code, sink_d_trim_code;
    logic signed [7:0] sink_a_trim_permil, sink_b_trim_permil, sink_c_trim_permil, sink_d_trim_permil;
    logic [3:0]  thermal_dim_gain, headroom_cmp_filter_len, power_switch_ocp_amps;
    logic [1:0]  power_switch_ocp_limit, power_switch_gate_current;
    logic [11:0] gate_current_ua;
    logic        soft_start_busy;
    // reference model: register bytes and decode tables in plain integers
    logic [7:0]  mdl [4];
    int          pm [16] = '{65, 56, 47, 37, 28, 19, 9, 0, -9, -19, -28, -37, -47, -56, -65, -74};
    int          pua [4] = '{55, 110, 220, 440};
    int          nua [4] = '{300, 500, 1000, 2200};
    int          error_cnt = 0, num_checks = 0, seed, i;

    always #5 sys_clk = ~sys_clk;

    ltcb_top i_ltcb_top (.sys_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .reg_hit, .sink_a_trim_code, .sink_b_trim_code, .sink_c_trim_code, .sink_d_trim_code,
        .sink_a_trim_permil, .sink_b_trim_permil, .sink_c_trim_permil, .sink_d_trim_permil, .thermal_dim_gain,
        .thermal_dim_enable, .pwm_tick, .headroom_cmp_raw, .headroom_cmp_filter_len, .headroom_cmp_qualified,
        .fault_recovery, .power_switch_n_type, .power_switch_ocp_limit, .power_switch_ocp_amps,
        .power_switch_gate_current, .gate_current_ua, .soft_start_go, .soft_start_busy);

    // single comparison point
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic results;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // all tasks start and end on a falling edge; wr leaves the strobe up so writes go back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_rd = 0;
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        if (a >= 8'h67 && a <= 8'h6a) mdl[a - 8'h67] = d;
    endtask

    // read and compare against the model, unmapped places read zero; strobe stays up for back-to-back reads
    task automatic rd(input logic [7:0] a);
        reg_wr = 0;
        reg_rd = 1;
        reg_addr = a;
        @(negedge sys_clk);
        chk(reg_hit, 32'(a >= 8'h67 && a <= 8'h6a));
        chk(reg_rvalid, 1);
        chk(reg_rdata, (a >= 8'h67 && a <= 8'h6a) ? mdl[a - 8'h67] : 8'h00);
    endtask

    // decoded outputs settle two edges after the write
    task automatic dchk;
        int g;
        reg_wr = 0;
        reg_rd = 0;
        g = mdl[3][1:0];
        repeat (3) @(negedge sys_clk);
        chk({sink_b_trim_code, sink_a_trim_code}, mdl[0]);
        chk({sink_d_trim_code, sink_c_trim_code}, mdl[1]);
        chk(32'(sink_a_trim_permil), 32'(pm[mdl[0][3:0]]));
        chk(32'(sink_b_trim_permil), 32'(pm[mdl[0][7:4]]));
        chk(32'(sink_c_trim_permil), 32'(pm[mdl[1][3:0]]));
        chk(32'(sink_d_trim_permil), 32'(pm[mdl[1][7:4]]));
        chk({thermal_dim_gain, headroom_cmp_filter_len}, mdl[2]);
        chk({thermal_dim_enable, power_switch_n_type}, mdl[3][7:6]);
        chk(power_switch_ocp_limit, mdl[3][3:2] < 2 ? 2 : mdl[3][3:2]);
        chk(power_switch_ocp_amps, mdl[3][3:2] == 3 ? 8 : 6);
        chk(power_switch_gate_current, g);
        chk(gate_current_ua, !mdl[3][6] ? pua[g] : (fault_recovery ? nua[g] : 0));
    endtask

    // pwm ticks spaced four clocks apart
    task automatic tick(input int k);
        repeat (k) begin
            pwm_tick = 1;
            @(negedge sys_clk);
            pwm_tick = 0;
            repeat (3) @(negedge sys_clk);
        end
    endtask

    // output holds for n-1 ticks of the new level, follows after n+1 as the first tick only starts the count
    task automatic flt(input logic [3:0] code, input int n, input logic lvl);
        wr(8'h69, {4'h0, code});
        reg_wr = 0;
        headroom_cmp_raw = lvl;
        repeat (4) @(negedge sys_clk);
        tick(n - 1);
        chk(headroom_cmp_qualified, !lvl);
        tick(2);
        repeat (8) @(negedge sys_clk);
        chk(headroom_cmp_qualified, lvl);
    endtask

    task automatic do_reset;
        srst = 1;
        repeat (4) @(negedge sys_clk);
        srst = 0;
        mdl = '{LTCB_RST_TRIM, LTCB_RST_TRIM, LTCB_RST_GAIN_FLT, LTCB_RST_PSW_SS};
    endtask

    // hang guard, span well above the expected run length
    initial begin
        #400000;
        error_cnt++;
        results();
    end

    initial begin
        seed = $urandom(32'h34ba23bf);
        @(negedge sys_clk);
        do_reset();
        // reset contents with neighbours on both sides
        for (i = 8'h66; i <= 8'h6b; i++) rd(8'(i));
        dchk();
        // every code of every field, back-to-back writes
        for (i = 0; i < 16; i++) begin
            wr(8'h67, {4'(i), 4'(15 - i)});
            wr(8'h68, {4'(15 - i), 4'(i)});
            wr(8'h69, {4'(i), 4'(15 - i)});
            wr(8'h6a, {i[0], i[1], i[3:2], i[3:2], i[1:0]});
            fault_recovery = i[2];
            dchk();
            for (int a = 8'h67; a <= 8'h6a; a++) rd(8'(a));
        end
        // random traffic including writes outside the bank that must be ignored
        repeat (40) wr(8'(8'h66 + $urandom_range(5)), 8'($urandom));
        fault_recovery = 1'($urandom);
        dchk();
        for (i = 8'h66; i <= 8'h6b; i++) rd(8'(i));
        // comparator filter: a drop back to the old level restarts the count, so 4+4 ticks never reach 5
        wr(8'h69, 8'h00);
        reg_wr = 0;
        headroom_cmp_raw = 1;
        tick(4);
        headroom_cmp_raw = 0;
        tick(2);
        headroom_cmp_raw = 1;
        tick(4);
        chk(headroom_cmp_qualified, 0);
        headroom_cmp_raw = 0;
        tick(2);
        flt(4'h0, 5, 1);
        flt(4'h0, 5, 0);
        flt(4'h3, 40, 1);
        flt(4'hf, 460, 0);
        // shortest soft-start still far longer than this watch
        wr(8'h6a, 8'h08);
        reg_wr = 0;
        soft_start_go = 1;
        @(negedge sys_clk);
        soft_start_go = 0;
        chk(soft_start_busy, 1);
        repeat (1000) @(negedge sys_clk);
        chk(soft_start_busy, 1);
        // reset in mid-run clears everything
        do_reset();
        chk(soft_start_busy, 0);
        for (i = 8'h67; i <= 8'h6a; i++) rd(8'(i));
        dchk();
        results();
    end
endmodule
`default_nettype wire
